// ### hw/irfl_pkg.sv
// Constants, offsets and field layouts of the interrupt request flag logic
package irfl_pkg;

    // ------------------------------------------------------------
    // Register byte offsets (one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TIMER_AND_EXT_IRQ_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_IEN    = 8'h04;
    localparam logic [7:0] OFS_IPRI   = 8'h08;
    localparam logic [7:0] OFS_TIMER2_MODE_AND_HW_CLEAR  = 8'h0C;
    localparam logic [7:0] OFS_EIEN   = 8'h10;
    localparam logic [7:0] OFS_EIPRI  = 8'h14;
    localparam logic [7:0] OFS_EXTENDED_IRQ_FLAGS   = 8'h18;
    localparam logic [7:0] OFS_DOG    = 8'h1C;
    localparam logic [7:0] OFS_UART   = 8'h20;
    localparam logic [7:0] OFS_T2FLG  = 8'h24;
    localparam logic [7:0] OFS_SVC    = 8'h28;
    localparam logic [7:0] OFS_PEND   = 8'h2C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TC_IT0  = 0;
    localparam int TC_IE0  = 1;
    localparam int TC_IT1  = 2;
    localparam int TC_IE1  = 3;
    localparam int TC_TF0  = 5;
    localparam int TC_TF1  = 7;
    localparam int IE_GATE = 7;
    localparam int EX_IE2  = 4;
    localparam int T2_HC2  = 4;
    localparam int DOG_TO  = 3;
    localparam int DOG_PF  = 4;
    localparam int EIE_DOG = 4;

    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG   = 8'h00;
    localparam logic [7:0] MASK_EIE  = 8'h1F;
    localparam logic [7:0] MASK_EXTENDED_IRQ_FLAGS = 8'hF0;
    localparam logic [7:0] MASK_DOG  = 8'h18;
    localparam logic [7:0] MASK_IP   = 8'h7F;

    // ------------------------------------------------------------
    // Sources in fixed resolution order, and their vectors
    // ------------------------------------------------------------
    localparam int NSRC = 12;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TMR1 = 3;
    localparam int SRC_UART0 = 4;
    localparam int SRC_TMR2 = 5;
    localparam int SRC_UART1 = 6;
    localparam int SRC_EXT2 = 7;
    localparam int SRC_DOG = 11;
    localparam logic [3:0]  SRC_PF = 4'hC;
    localparam logic [3:0]  SRC_NONE = 4'hF;
    localparam logic [15:0] VEC_PF = 16'h0033;
    localparam logic [15:0] VEC_TAB [0:11] = '{
        16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
        16'h003B, 16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063};

    // ------------------------------------------------------------
    // Bus slave states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_RDWAIT = 2'b10
    } irfl_bus_e;

endpackage

// ### hw/irfl_core.sv
// Interrupt request flags, enables, priority resolution and AHB-Lite register slave
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module irfl_core
    import irfl_pkg::*;
(
    // Clock, reset, enable
    input  wire  logic        clk_sys,
    input  wire  logic        nrst,
    input  wire  logic        clk_en,
    // AHB-Lite slave
    input  wire  logic        hsel,
    input  wire  logic [31:0] haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    output logic       [31:0] hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // Pins and peripheral events
    input  wire  logic        mc_tick,
    input  wire  logic [5:0]  ext_irq_pin_n,
    input  wire  logic        tmr0_ovf,
    input  wire  logic        tmr1_ovf,
    input  wire  logic        tmr2_ovf,
    input  wire  logic        tmr2_capture,
    input  wire  logic        uart0_rx_done,
    input  wire  logic        uart0_tx_done,
    input  wire  logic        uart1_rx_done,
    input  wire  logic        uart1_tx_done,
    input  wire  logic        dog_timeout,
    input  wire  logic        power_fail,
    // Core sequencer
    input  wire  logic        instr_last_cycle,
    input  wire  logic        instr_blocks_irq,
    input  wire  logic        return_from_handler,
    output logic              vec_req,
    output logic       [15:0] vec_addr,
    output logic       [3:0]  vec_src
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    irfl_bus_e   bus_st_r;
    logic [7:0]  addr_r;
    logic        wr_pend_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    logic        hresp_r;
    logic [7:0]  timer_and_ext_irq_control, timer_and_ext_irq_control_nxt;
    logic [7:0]  irq_enable_main, irq_priority_main;
    logic [7:0]  timer2_mode_and_hw_clear, extended_irq_enable, extended_irq_priority;
    logic [7:0]  extended_irq_flags, extended_irq_flags_nxt;
    logic [7:0]  dog_control_reg, dog_nxt;
    logic [3:0]  uart_flags_r, uart_nxt;
    logic [1:0]  tmr2_flags_r, t2f_nxt;
    logic [5:0]  pin_q_r;
    logic [5:0]  fall_v;
    logic        svc_lo_r, svc_hi_r, svc_pf_r;
    logic        vec_req_r;
    logic [15:0] vec_addr_r;
    logic [3:0]  vec_src_r;
    logic [11:0] req_v, en_v, pri_v, act_v, hi_v, lo_v, sel_v, auto_v, take_oh_v, clr_v;
    logic        pf_cand, take_now, take_pf;
    logic [3:0]  take_idx;
    logic [31:0] rd_mux;
    logic        acc, wr_timer_and_ext_irq_control, wr_extended_irq_flags, wr_dog, wr_uart, wr_t2f;
    logic [7:0]  wd;

    // Lowest set index wins; all-zero gives SRC_NONE
    function automatic logic [3:0] first_idx(input logic [11:0] v);
        logic [3:0] r;
        r = SRC_NONE;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // AHB-Lite slave: zero-wait writes, one-wait reads
    // ------------------------------------------------------------
    assign acc = hsel && htrans[1] && hready;
    assign wd  = hwdata[7:0];
    assign wr_timer_and_ext_irq_control = wr_pend_r && (addr_r == OFS_TIMER_AND_EXT_IRQ_CONTROL);
    assign wr_extended_irq_flags = wr_pend_r && (addr_r == OFS_EXTENDED_IRQ_FLAGS);
    assign wr_dog  = wr_pend_r && (addr_r == OFS_DOG);
    assign wr_uart = wr_pend_r && (addr_r == OFS_UART);
    assign wr_t2f  = wr_pend_r && (addr_r == OFS_T2FLG);

    // Address phase capture and read wait state
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            bus_st_r    <= BUS_IDLE;
            addr_r      <= RST_REG;
            wr_pend_r   <= 1'b0;
            hrdata_r    <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end else if (clk_en) begin
            case (bus_st_r)
                BUS_IDLE: begin
                    wr_pend_r <= acc && hwrite;
                    if (acc) begin
                        addr_r <= haddr[7:0];
                    end
                    if (acc && !hwrite) begin
                        bus_st_r    <= BUS_RDWAIT;
                        hreadyout_r <= 1'b0;
                    end
                end
                BUS_RDWAIT: begin
                    wr_pend_r   <= 1'b0;
                    hrdata_r    <= rd_mux;
                    hreadyout_r <= 1'b1;
                    bus_st_r    <= BUS_IDLE;
                end
                default: begin
                    bus_st_r    <= BUS_IDLE;
                    wr_pend_r   <= 1'b0;
                    hreadyout_r <= 1'b1;
                end
            endcase
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        case (addr_r)
            OFS_TIMER_AND_EXT_IRQ_CONTROL:  rd_mux = {24'h0, timer_and_ext_irq_control};
            OFS_IEN:   rd_mux = {24'h0, irq_enable_main};
            OFS_IPRI:  rd_mux = {24'h0, irq_priority_main};
            OFS_TIMER2_MODE_AND_HW_CLEAR: rd_mux = {24'h0, timer2_mode_and_hw_clear};
            OFS_EIEN:  rd_mux = {24'h0, extended_irq_enable};
            OFS_EIPRI: rd_mux = {24'h0, extended_irq_priority};
            OFS_EXTENDED_IRQ_FLAGS:  rd_mux = {24'h0, extended_irq_flags};
            OFS_DOG:   rd_mux = {24'h0, dog_control_reg};
            OFS_UART:  rd_mux = {28'h0, uart_flags_r};
            OFS_T2FLG: rd_mux = {30'h0, tmr2_flags_r};
            OFS_SVC:   rd_mux = {29'h0, svc_pf_r, svc_hi_r, svc_lo_r};
            OFS_PEND:  rd_mux = {20'h0, act_v};
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Enables, priorities and hardware-clear selects
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            irq_enable_main          <= RST_REG;
            extended_irq_enable      <= RST_REG;
            irq_priority_main        <= RST_REG;
            extended_irq_priority    <= RST_REG;
            timer2_mode_and_hw_clear <= RST_REG;
        end else if (clk_en && wr_pend_r) begin
            case (addr_r)
                OFS_IEN:   irq_enable_main          <= wd;
                OFS_IPRI:  irq_priority_main        <= wd & MASK_IP;
                OFS_TIMER2_MODE_AND_HW_CLEAR: timer2_mode_and_hw_clear <= wd;
                OFS_EIEN:  extended_irq_enable      <= wd & MASK_EIE;
                OFS_EIPRI: extended_irq_priority    <= wd & MASK_EIE;
                default:   irq_enable_main          <= irq_enable_main;
            endcase
        end
    end

    // ------------------------------------------------------------
    // External pin sampling
    // ------------------------------------------------------------
    // One sample per machine cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_q_r <= 6'h3F;
        end else if (clk_en && mc_tick) begin
            pin_q_r <= ext_irq_pin_n;
        end
    end

    // Falling transition between two machine-cycle samples
    for (genvar g = 0; g < 6; g++) begin : g_fall
        assign fall_v[g] = mc_tick && pin_q_r[g] && !ext_irq_pin_n[g];
    end

    // ------------------------------------------------------------
    // Request flags
    // ------------------------------------------------------------
    // Sources that clear their own flag on vectoring
    assign auto_v = {1'b0, timer2_mode_and_hw_clear[7:T2_HC2], 3'h0, 1'b1,
                     timer_and_ext_irq_control[TC_IT1], 1'b1,
                     timer_and_ext_irq_control[TC_IT0]};
    assign clr_v  = take_pf ? 12'h000 : (take_oh_v & auto_v);

    // Next values: software write, hardware clear, then sets on top
    always_comb begin
        timer_and_ext_irq_control_nxt = wr_timer_and_ext_irq_control ? wd : timer_and_ext_irq_control;
        extended_irq_flags_nxt = wr_extended_irq_flags ? (wd & MASK_EXTENDED_IRQ_FLAGS) : extended_irq_flags;
        dog_nxt  = wr_dog ? (wd & MASK_DOG) : dog_control_reg;
        uart_nxt = wr_uart ? wd[3:0] : uart_flags_r;
        t2f_nxt  = wr_t2f ? wd[1:0] : tmr2_flags_r;
        if (clr_v[SRC_EXT0]) timer_and_ext_irq_control_nxt[TC_IE0] = 1'b0;
        if (clr_v[SRC_TMR0]) timer_and_ext_irq_control_nxt[TC_TF0] = 1'b0;
        if (clr_v[SRC_EXT1]) timer_and_ext_irq_control_nxt[TC_IE1] = 1'b0;
        if (clr_v[SRC_TMR1]) timer_and_ext_irq_control_nxt[TC_TF1] = 1'b0;
        extended_irq_flags_nxt[7:4] = extended_irq_flags_nxt[7:4] & ~clr_v[10:7];
        // Level mode follows the sampled pin
        if (mc_tick && !timer_and_ext_irq_control[TC_IT0]) timer_and_ext_irq_control_nxt[TC_IE0] = !ext_irq_pin_n[0];
        if (mc_tick && !timer_and_ext_irq_control[TC_IT1]) timer_and_ext_irq_control_nxt[TC_IE1] = !ext_irq_pin_n[1];
        // Sets win over every clear
        if (fall_v[0] && timer_and_ext_irq_control[TC_IT0]) timer_and_ext_irq_control_nxt[TC_IE0] = 1'b1;
        if (fall_v[1] && timer_and_ext_irq_control[TC_IT1]) timer_and_ext_irq_control_nxt[TC_IE1] = 1'b1;
        if (tmr0_ovf) timer_and_ext_irq_control_nxt[TC_TF0] = 1'b1;
        if (tmr1_ovf) timer_and_ext_irq_control_nxt[TC_TF1] = 1'b1;
        extended_irq_flags_nxt[7:4] = extended_irq_flags_nxt[7:4] | fall_v[5:2];
        if (dog_timeout) dog_nxt[DOG_TO] = 1'b1;
        if (power_fail)  dog_nxt[DOG_PF] = 1'b1;
        uart_nxt = uart_nxt | {uart1_tx_done, uart1_rx_done, uart0_tx_done, uart0_rx_done};
        t2f_nxt  = t2f_nxt | {tmr2_capture, tmr2_ovf};
    end

    // Flag registers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            timer_and_ext_irq_control <= RST_REG;
            extended_irq_flags        <= RST_REG;
            dog_control_reg           <= RST_REG;
            uart_flags_r              <= 4'h0;
            tmr2_flags_r              <= 2'h0;
        end else if (clk_en) begin
            timer_and_ext_irq_control <= timer_and_ext_irq_control_nxt;
            extended_irq_flags        <= extended_irq_flags_nxt;
            dog_control_reg           <= dog_nxt;
            uart_flags_r              <= uart_nxt;
            tmr2_flags_r              <= t2f_nxt;
        end
    end

    // ------------------------------------------------------------
    // Enable, priority and resolution
    // ------------------------------------------------------------
    assign req_v = {dog_control_reg[DOG_TO], extended_irq_flags[7:EX_IE2],
                    uart_flags_r[3] | uart_flags_r[2], |tmr2_flags_r,
                    uart_flags_r[1] | uart_flags_r[0],
                    timer_and_ext_irq_control[TC_TF1], timer_and_ext_irq_control[TC_IE1],
                    timer_and_ext_irq_control[TC_TF0], timer_and_ext_irq_control[TC_IE0]};
    assign en_v  = {extended_irq_enable[4:0], irq_enable_main[6:0]};
    assign pri_v = {extended_irq_priority[4:0], irq_priority_main[6:0]};
    assign act_v = req_v & en_v & {NSRC{irq_enable_main[IE_GATE]}};
    assign hi_v  = act_v & pri_v;
    assign lo_v  = act_v & ~pri_v;

    // Power fail ignores the gate; levels honour those in service
    assign pf_cand = dog_control_reg[DOG_PF] && !svc_pf_r;
    assign sel_v   = svc_pf_r ? 12'h000 :
                     (|hi_v && !svc_hi_r) ? hi_v :
                     (!svc_hi_r && !svc_lo_r) ? lo_v : 12'h000;
    assign take_idx = first_idx(sel_v);
    assign take_now = clk_en && mc_tick && instr_last_cycle && !instr_blocks_irq
                      && (pf_cand || |sel_v);
    assign take_pf  = pf_cand;
    assign take_oh_v = take_now ? (sel_v & ~(sel_v - 12'h001)) : 12'h000;

    // ------------------------------------------------------------
    // Vectoring and in-service tracking
    // ------------------------------------------------------------
    // Vector pulse to the core sequencer
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            vec_req_r  <= 1'b0;
            vec_addr_r <= 16'h0000;
            vec_src_r  <= SRC_NONE;
        end else if (clk_en) begin
            vec_req_r <= take_now;
            if (take_now) begin
                vec_src_r  <= take_pf ? SRC_PF : take_idx;
                vec_addr_r <= take_pf ? VEC_PF : VEC_TAB[take_idx];
            end
        end
    end

    // In-service levels; return releases the highest one
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            svc_lo_r <= 1'b0;
            svc_hi_r <= 1'b0;
            svc_pf_r <= 1'b0;
        end else if (clk_en) begin
            if (take_now && take_pf) begin
                svc_pf_r <= 1'b1;
            end else if (take_now && pri_v[take_idx]) begin
                svc_hi_r <= 1'b1;
            end else if (take_now) begin
                svc_lo_r <= 1'b1;
            end else if (return_from_handler && svc_pf_r) begin
                svc_pf_r <= 1'b0;
            end else if (return_from_handler && svc_hi_r) begin
                svc_hi_r <= 1'b0;
            end else if (return_from_handler) begin
                svc_lo_r <= 1'b0;
            end
        end
    end

    // Outputs straight from flip-flops
    assign hrdata    = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp     = hresp_r;
    assign vec_req   = vec_req_r;
    assign vec_addr  = vec_addr_r;
    assign vec_src   = vec_src_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_edge0;
        clk_en && fall_v[0] && timer_and_ext_irq_control[TC_IT0];
    endsequence

    sequence s_low0_level;
        clk_en && mc_tick && !timer_and_ext_irq_control[TC_IT0] && !ext_irq_pin_n[0];
    endsequence

    chk_edge_sets_flag: assert property (s_edge0 |=> timer_and_ext_irq_control[TC_IE0])
        else $error("edge on input 0 did not set its flag");

    chk_level_keeps_req: assert property (s_low0_level |=> timer_and_ext_irq_control[TC_IE0])
        else $error("low level on input 0 did not request");

    chk_ext0_autoclr: assert property (clk_en && clr_v[SRC_EXT0] && !fall_v[0]
        |=> !timer_and_ext_irq_control[TC_IE0])
        else $error("edge flag of input 0 not cleared on entry");

    chk_hc_clear: assert property (take_now && !take_pf && take_idx == 4'd7 && timer2_mode_and_hw_clear[T2_HC2]
        && !fall_v[2] |=> !extended_irq_flags[EX_IE2])
        else $error("hardware clear of input 2 flag missing");

    chk_tmr0_clear: assert property (take_now && !take_pf && take_idx == 4'd1 && !tmr0_ovf
        |=> !timer_and_ext_irq_control[TC_TF0])
        else $error("timer 0 flag not cleared on entry");

    chk_t2_no_clear: assert property (clk_en && tmr2_flags_r[0] && !wr_t2f |=> tmr2_flags_r[0])
        else $error("timer 2 flag cleared by hardware");

    chk_uart_hold: assert property (clk_en && uart_flags_r[0] && !wr_uart ##1 clk_en && !wr_uart
        |=> uart_flags_r[0])
        else $error("serial flag cleared by hardware");

    chk_dog_gate: assert property (dog_control_reg[DOG_TO] && !extended_irq_enable[EIE_DOG] && take_now
        |-> take_pf || take_idx != 4'(SRC_DOG))
        else $error("watchdog vectored while disabled");

    chk_gate_blocks: assert property (!irq_enable_main[IE_GATE] && !dog_control_reg[DOG_PF] |-> !take_now)
        else $error("vector taken with gate cleared");

    chk_fixed_order: assert property (take_now && !take_pf |-> (sel_v & (take_oh_v - 12'h001)) == 12'h000)
        else $error("lower-order source chosen first");

    chk_vec_cause: assert property (vec_req_r && $past(clk_en) |-> $past(instr_last_cycle)
        && !$past(instr_blocks_irq) && vec_addr_r == (vec_src_r == SRC_PF ? VEC_PF : VEC_TAB[vec_src_r]))
        else $error("vector issued without its conditions");

    chk_svc_blocks: assert property (svc_hi_r && !dog_control_reg[DOG_PF] |-> !take_now)
        else $error("vector taken over a high-level routine");

    chk_reset_enables: assert property (@(posedge clk_sys) disable iff (1'b0)
        !nrst |=> irq_enable_main == RST_REG && extended_irq_enable == RST_REG)
        else $error("enables not cleared by reset");

    chk_sw_sets_flag: assert property (clk_en && wr_timer_and_ext_irq_control && wd[TC_IE1] && timer_and_ext_irq_control[TC_IT1]
        && !clr_v[SRC_EXT1] |=> timer_and_ext_irq_control[TC_IE1])
        else $error("software write did not set flag");

endmodule

// ### tb/irfl_partner.sv
// Core sequencer model: machine-cycle ticks, instruction ends, handler returns
`timescale 1ns/1ps
module irfl_partner (
    // Clock and reset
    input  wire  logic clk_sys,
    input  wire  logic nrst,
    // Core link
    input  wire  logic vec_req,
    output logic       mc_tick,
    output logic       instr_last_cycle,
    output logic       instr_blocks_irq,
    output logic       return_from_handler
);
    logic [1:0] ph_r;
    logic [4:0] ret_r;
    logic       last_r;
    // Every second machine cycle ends a harmless instruction
    assign instr_last_cycle = last_r;
    assign instr_blocks_irq = 1'b0;
    always_ff @(posedge clk_sys) begin
        if (!nrst) last_r <= 1'b0;
        else if (mc_tick) last_r <= !last_r;
    end
    // One sample point per four clocks
    assign mc_tick = (ph_r == 2'h3);
    always_ff @(posedge clk_sys) begin
        ph_r <= nrst ? ph_r + 2'h1 : 2'h0;
    end
    // Handler runs sixteen clocks, then returns
    assign return_from_handler = (ret_r == 5'h01);
    always_ff @(posedge clk_sys) begin
        if (!nrst) ret_r <= 5'h00;
        else if (vec_req) ret_r <= 5'h10;
        else if (ret_r != 5'h00) ret_r <= ret_r - 5'h01;
    end
endmodule

// ### tb/tb_interrupt_request_flag_logic.sv
// Self-checking bench of the interrupt request flag logic
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_interrupt_request_flag_logic;
    import irfl_pkg::*;
    logic clk_sys, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, tick, last, blk, ret, vreq, hrdy, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [5:0] pins = 6'h3F;
    logic [9:0] ev = 10'h000;
    logic [15:0] vaddr;
    logic [3:0] vsrc;
    int error_cnt = 0, n_tests = 0;
    // Flag place, flag value, enables, vector, flag after entry, source
    logic [51:0] rows [3] = '{{OFS_TIMER_AND_EXT_IRQ_CONTROL, 8'h20, 8'h82, 16'h000B, 8'h00, 4'h1},
        {OFS_UART, 8'h01, 8'h90, 16'h0023, 8'h01, 4'h4}, {OFS_T2FLG, 8'h02, 8'hA0, 16'h002B, 8'h02, 4'h5}};
    irfl_core dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .mc_tick(tick), .ext_irq_pin_n(pins),
        .tmr0_ovf(ev[0]), .tmr1_ovf(ev[1]), .tmr2_ovf(ev[2]), .tmr2_capture(ev[3]),
        .uart0_rx_done(ev[4]), .uart0_tx_done(ev[5]), .uart1_rx_done(ev[6]), .uart1_tx_done(ev[7]),
        .dog_timeout(ev[8]), .power_fail(ev[9]), .instr_last_cycle(last), .instr_blocks_irq(blk),
        .return_from_handler(ret), .vec_req(vreq), .vec_addr(vaddr), .vec_src(vsrc));
    irfl_partner core (.clk_sys(clk_sys), .nrst(nrst), .vec_req(vreq), .mc_tick(tick),
        .instr_last_cycle(last), .instr_blocks_irq(blk), .return_from_handler(ret));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Verdict and end of run
    task results;
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Bounded wait for the slave to be ready at an edge
    task wt;
        int i;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
            if (i > 50) begin error_cnt++; results; end
        end while (hrdy !== 1'b1);
    endtask
    // One single-word transfer
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
        wt;
        htrans <= 2'h0; hwdata <= d; hsel <= 1'b0;
        wt;
        q = hrdata;
        `CHK(hresp, 1'b0)
    endtask
    // Bounded wait for a vector, then its address check
    task vec(input logic [15:0] e, input logic [3:0] s);
        int i;
        i = 0;
        do begin
            @(posedge clk_sys); #1;
            i++;
            if (i > 200) begin error_cnt++; results; end
        end while (vreq !== 1'b1);
        `CHK(vaddr, e)
        `CHK(vsrc, s)
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        // Software-set flags request for real; hardware clears the timer 0 flag but not the serial or timer 2 flags
        foreach (rows[k]) begin
            bus(1'b1, OFS_IEN, {24'h0, rows[k][35:28]});
            bus(1'b1, rows[k][51:44], {24'h0, rows[k][43:36]});
            vec(rows[k][27:12], rows[k][3:0]);
            bus(1'b0, rows[k][51:44], 32'h0);
            `CHK(q[7:0], rows[k][11:4])
            bus(1'b1, rows[k][51:44], 32'h0);
            bus(1'b1, OFS_IEN, 32'h0);
        end
        // Falling edge on input 0 in edge mode, pin held a machine cycle each way
        bus(1'b1, OFS_TIMER_AND_EXT_IRQ_CONTROL, 32'h01);
        bus(1'b1, OFS_IEN, 32'h81);
        repeat (8) @(posedge clk_sys);
        pins <= 6'h3E;
        vec(16'h0003, 4'h0);
        pins <= 6'h3F;
        bus(1'b0, OFS_TIMER_AND_EXT_IRQ_CONTROL, 32'h0);
        `CHK(q[7:0], 8'h01)
        // Second reset leaves enables cleared
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        bus(1'b0, OFS_IEN, 32'h0);
        `CHK(q, 32'h0)
        results;
    end
endmodule
